// ===== hw/iaoc_top.sv
// Two interlocked auxiliary power outputs with APB configuration.
// Assumes switch and status pins are asynchronous; current in 0.1 A units.
// Byte-addressed register map; every output leaves a flip-flop.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// How it works
// RQ1 - Configurer programs gear code for gear settings
// RQ2 - Gear code: neutral 125, forward/reverse offsets
// RQ3 - Gear code used only by settings 13, 14
// RQ4 - Output trips off at programmed current
// RQ5 - Latch-off holds output until switch recycled
// RQ6 - Per channel speed threshold, default 30
// RQ7 - Per channel gear code 0..250, default 0
// RQ8 - Two independent channels, own switch, parameters
// RQ9 - Violated interlock turns output off
// RQ10 - Selector settings 0..16 choose interlock
// RQ11 - Without latch, output returns when condition holds
// RQ12 - Speed settings compare speed with threshold
// RQ13 - Everything re-evaluated every clock cycle
module iaoc_top #(
	parameter int NUM_CH = iaoc_pkg::NCH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_CH-1:0] switch_in,
	input wire logic [NUM_CH-1:0] [7:0] current_in,
	input wire iaoc_pkg::iaoc_veh_t veh_in,
	output logic [NUM_CH-1:0] power_out,
	output logic irq
);
	import iaoc_pkg::*;

	// Stage width: switches, status word, one current per channel
	localparam int VW = $bits(iaoc_veh_t);
	localparam int SW = NUM_CH + VW + $bits(current_in);

	// Configuration, one record per channel
	iaoc_cfg_t cfg_r [NUM_CH];
	// Pin stages
	logic [SW-1:0] s1_r;
	logic [SW-1:0] s2_r;
	logic [SW-1:0] s3_r;
	// Filtered pin fields
	iaoc_veh_t veh;
	logic [NUM_CH-1:0] sw;
	// Channel state
	logic [NUM_CH-1:0] sw_d_r;
	logic [NUM_CH-1:0] ok;
	logic [NUM_CH-1:0] latched_r;
	logic [NUM_CH-1:0] tripped_r;
	logic [NUM_CH-1:0] trip_hit;
	logic [NUM_CH-1:0] ok_d_r;
	// Event status, mask and raw events
	logic [2*NUM_CH-1:0] ist_r;
	logic [2*NUM_CH-1:0] imask_r;
	logic [2*NUM_CH-1:0] ev;
	logic [NUM_CH-1:0] drop_ev;
	logic [NUM_CH-1:0] trip_ev;
	// Bus strobes
	logic wr;
	logic rd;

	// Channel decode, used by both write and read paths
	// Channels sit one stride apart from the base
	function automatic logic ch_hit(input logic [7:0] a, input int c,
		input logic [3:0] ofs);
		logic [7:0] base;
		base = OFS_CH_BASE + 8'(c) * OFS_CH_STRIDE;
		return a == (base + {4'h0, ofs});
	endfunction : ch_hit

	// Clamp a value into an allowed range
	// Out-of-range writes land on the nearest limit
	function automatic logic [7:0] clamp8(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		if (v < lo)
			return lo;
		if (v > hi)
			return hi;
		return v;
	endfunction : clamp8

	// Interlock condition for one channel
	function automatic logic cond_ok(input iaoc_cfg_t c,
		input iaoc_veh_t v);
		case (c.sel)
			IAOC_NONE: return 1'b1; // [RQ10]
			// Park brake and doors
			IAOC_PARK_ON: return v.park_brake;
			IAOC_PARK_OFF: return !v.park_brake;
			IAOC_DOOR_OPEN: return v.door_open;
			IAOC_DOOR_SHUT: return !v.door_open;
			// Power takeoff and engine
			IAOC_PTO_ON: return v.power_takeoff;
			IAOC_PTO_OFF: return !v.power_takeoff;
			IAOC_ENG_RUN: return v.engine_run;
			IAOC_ENG_STOP: return !v.engine_run;
			// Speed and motion
			IAOC_SPD_ABOVE: return v.speed > c.speed; // [RQ12]
			IAOC_SPD_BELOW: return v.speed < c.speed; // [RQ12]
			IAOC_STOPPED: return !v.moving;
			IAOC_MOVING: return v.moving;
			// Gear code read only here [RQ3] [RQ1]
			IAOC_GEAR_ABOVE: return v.gear > c.gear;
			IAOC_GEAR_BELOW: return v.gear < c.gear;
			IAOC_NEUTRAL: return v.gear == GEAR_NEUTRAL; // [RQ2]
			IAOC_NOT_NEUTRAL: return v.gear != GEAR_NEUTRAL; // [RQ2]
			default: return 1'b0; // Out-of-range setting keeps output off
		endcase
	endfunction : cond_ok

	// Write lands at the access edge; read mux taken in setup
	// Neither waits on pready, which is high in every access
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;

	// Pin synchroniser, change taken once stages two and three agree
	// Stage one may go metastable; only stage two reads it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= {switch_in, veh_in, current_in};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Filtered copy of pins; holds old value while stages disagree
	// A pin glitch of one cycle never reaches the outputs
	logic [SW-1:0] filt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			filt_r <= '0;
		else
			filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
	end

	// Filtered word split back into switches, status and currents
	logic [NUM_CH-1:0] [7:0] cur;
	assign {sw, veh, cur} = filt_r;

	// Register map, byte addresses:
	//   channel n base plus 0x00: selector, threshold, latch-off
	//   base plus 0x04: gear code, used by gear settings only
	//   base plus 0x08: trip value in tenths of an ampere
	//   0x20: filtered vehicle status, read only
	//   0x24: latched, tripped, switch, output; two bits each
	//   0x28: event status, write one to clear
	//   0x2c: event mask, same layout as the status
	//   Anything else answers with a slave error

	// Channel configuration registers [RQ8]
	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_cfg
			// One write updates one field group of one channel
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg_r[c].sel <= SEL_DEFAULT;
					cfg_r[c].speed <= SPEED_DEFAULT; // [RQ6]
					cfg_r[c].gear <= GEAR_DEFAULT; // [RQ7]
					cfg_r[c].trip <= TRIP_DEFAULT; // [RQ4]
					cfg_r[c].latch <= 1'b0; // [RQ5]
				end else if (wr && ch_hit(paddr, c, OFS_CFG)) begin
					// Settings above 16 are refused, old one kept [RQ10]
					if (pwdata[CFG_SEL_LSB +: 5] <= SEL_MAX)
						cfg_r[c].sel <= pwdata[CFG_SEL_LSB +: 5];
					cfg_r[c].speed <= 7'(clamp8(
						{1'b0, pwdata[CFG_SPD_LSB +: 7]}, 8'h00,
						{1'b0, SPEED_MAX})); // [RQ6]
					cfg_r[c].latch <= pwdata[CFG_LATCH_BIT];
				end else if (wr && ch_hit(paddr, c, OFS_GEAR)) begin
					cfg_r[c].gear <= clamp8(pwdata[7:0], 8'h00,
						GEAR_MAX); // [RQ7]
				end else if (wr && ch_hit(paddr, c, OFS_TRIP)) begin
					cfg_r[c].trip <= clamp8(pwdata[7:0], TRIP_MIN,
						TRIP_MAX); // [RQ4]
				end
			end
		end
	endgenerate

	// Per-channel output control, evaluated every cycle [RQ13]
	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
			// Condition picked by the channel's selector
			assign ok[c] = cond_ok(cfg_r[c], veh);
			// Tenths of an ampere; reaching the value already trips
			assign trip_hit[c] = cur[c] >= cfg_r[c].trip; // [RQ4]

			// Trip holds until switch off, so a live short cannot
			// toggle the driver on and off
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					tripped_r[c] <= 1'b0;
				else if (!sw[c])
					tripped_r[c] <= 1'b0;
				else if (trip_hit[c])
					tripped_r[c] <= 1'b1; // [RQ4]
			end

			// Latch-off clears only on switch off; recycling re-arms
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					latched_r[c] <= 1'b0;
				else if (!sw[c])
					latched_r[c] <= 1'b0; // [RQ5]
				else if (!ok[c] && cfg_r[c].latch)
					latched_r[c] <= 1'b1; // [RQ5]
			end

			// Output off on violation, back on when ok [RQ9] [RQ11]
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					power_out[c] <= 1'b0;
				else
					power_out[c] <= sw[c] && ok[c] && !trip_hit[c] &&
						!tripped_r[c] && !latched_r[c]; // [RQ13]
			end
		end
	endgenerate

	// Edge history for interlock drop events
	// ok resets high; switch history resets low so that reset itself logs no drop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ok_d_r <= '1;
			sw_d_r <= '0;
		end else begin
			ok_d_r <= ok;
			sw_d_r <= sw;
		end
	end

	// Interlock drop: condition falls while switch stays on
	assign drop_ev = ok_d_r & ~ok & sw & sw_d_r;
	// Current trip: first cycle at or above the trip value
	assign trip_ev = trip_hit & sw & ~tripped_r;
	// Events: low bits interlock drop, high bits current trip
	assign ev = {trip_ev, drop_ev};

	// Sticky status; a new event wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ist_r <= '0;
		else if (wr && paddr == OFS_IRQ_ST)
			ist_r <= (ist_r & ~pwdata[2*NUM_CH-1:0]) | ev;
		else
			ist_r <= ist_r | ev;
	end

	// Mask, same layout as the status; a one enables the line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			imask_r <= '0;
		else if (wr && paddr == OFS_IRQ_MASK)
			imask_r <= pwdata[2*NUM_CH-1:0];
	end

	// Level line, one cycle behind status and mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(ist_r & imask_r);
	end

	// Read mux, registered in setup so access completes at once
	logic [31:0] rd_nxt;
	logic rd_err;
	always_comb begin
		rd_nxt = '0;
		rd_err = 1'b1;
		// Channel words
		for (int c = 0; c < NUM_CH; c++) begin
			if (ch_hit(paddr, c, OFS_CFG)) begin
				rd_nxt[CFG_SEL_LSB +: 5] = cfg_r[c].sel;
				rd_nxt[CFG_SPD_LSB +: 7] = cfg_r[c].speed;
				rd_nxt[CFG_LATCH_BIT] = cfg_r[c].latch;
				rd_err = 1'b0;
			end
			if (ch_hit(paddr, c, OFS_GEAR)) begin
				rd_nxt[7:0] = cfg_r[c].gear;
				rd_err = 1'b0;
			end
			if (ch_hit(paddr, c, OFS_TRIP)) begin
				rd_nxt[7:0] = cfg_r[c].trip;
				rd_err = 1'b0;
			end
		end
		// Shared words
		case (paddr)
			OFS_VEH: begin
				rd_nxt[VW-1:0] = veh;
				rd_err = 1'b0;
			end
			OFS_STAT: begin
				rd_nxt[4*NUM_CH-1:0] = {latched_r, tripped_r, sw,
					power_out};
				rd_err = 1'b0;
			end
			OFS_IRQ_ST: begin
				rd_nxt[2*NUM_CH-1:0] = ist_r;
				rd_err = 1'b0;
			end
			OFS_IRQ_MASK: begin
				rd_nxt[2*NUM_CH-1:0] = imask_r;
				rd_err = 1'b0;
			end
			default: ;
		endcase
	end

	// Read word and error taken in setup, held through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata <= rd ? rd_nxt : 32'h0000_0000;
			pslverr <= rd_err;
		end
	end

	// Zero wait states: every access ends one cycle
	// after its setup, so pready never stretches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel && !penable;
	end
endmodule : iaoc_top

// ===== hw/iaoc_pkg.sv
// Package for the interlocked auxiliary output controller.
// Assumes one 50 MHz clock domain and an APB register bus.
package iaoc_pkg;
	localparam int NCH = 2;
	// Register byte offsets
	localparam logic [7:0] OFS_CH_BASE = 8'h00;
	localparam logic [7:0] OFS_CH_STRIDE = 8'h10;
	localparam logic [3:0] OFS_CFG = 4'h0;
	localparam logic [3:0] OFS_GEAR = 4'h4;
	localparam logic [3:0] OFS_TRIP = 4'h8;
	localparam logic [7:0] OFS_VEH = 8'h20;
	localparam logic [7:0] OFS_STAT = 8'h24;
	localparam logic [7:0] OFS_IRQ_ST = 8'h28;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
	// Defaults and codes
	localparam logic [4:0] SEL_DEFAULT = 5'h0a;
	localparam logic [4:0] SEL_MAX = 5'h10;
	localparam logic [6:0] SPEED_DEFAULT = 7'h1e;
	localparam logic [6:0] SPEED_MAX = 7'h64;
	localparam logic [7:0] GEAR_DEFAULT = 8'h00;
	localparam logic [7:0] GEAR_MAX = 8'hfa;
	localparam logic [7:0] GEAR_NEUTRAL = 8'h7d;
	// Trip value in tenths of an ampere
	localparam logic [7:0] TRIP_DEFAULT = 8'hc8;
	localparam logic [7:0] TRIP_MIN = 8'h0a;
	localparam logic [7:0] TRIP_MAX = 8'hc8;
	// Field positions in channel config word
	localparam int CFG_SEL_LSB = 0;
	localparam int CFG_SPD_LSB = 8;
	localparam int CFG_LATCH_BIT = 16;
	typedef enum logic [4:0] {
		IAOC_NONE, IAOC_PARK_ON, IAOC_PARK_OFF, IAOC_DOOR_OPEN,
		IAOC_DOOR_SHUT, IAOC_PTO_ON, IAOC_PTO_OFF, IAOC_ENG_RUN,
		IAOC_ENG_STOP, IAOC_SPD_ABOVE, IAOC_SPD_BELOW, IAOC_STOPPED,
		IAOC_MOVING, IAOC_GEAR_ABOVE, IAOC_GEAR_BELOW, IAOC_NEUTRAL,
		IAOC_NOT_NEUTRAL
	} iaoc_sel_t;
	typedef struct packed {
		logic [4:0] sel;
		logic [6:0] speed;
		logic [7:0] gear;
		logic [7:0] trip;
		logic latch;
	} iaoc_cfg_t;
	typedef struct packed {
		logic park_brake;
		logic door_open;
		logic power_takeoff;
		logic engine_run;
		logic moving;
		logic [6:0] speed;
		logic [7:0] gear;
	} iaoc_veh_t;
endpackage : iaoc_pkg

// ===== sim/iaoc_checker.sv
// Port assertions for the interlocked output block.
// Bound to iaoc_top; cab pins are held for many clocks at a time.
`timescale 1ns/1ps
module iaoc_checker #(
	parameter int NUM_CH = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NUM_CH-1:0] switch_in,
	input wire logic [NUM_CH-1:0] [7:0] current_in,
	input wire logic [NUM_CH-1:0] power_out,
	input wire logic irq
);
	import iaoc_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus setup cycle and long switch-off spells
	sequence s_setup; psel && !penable; endsequence
	sequence s_off0; !switch_in[0] [*8]; endsequence
	sequence s_off1; !switch_in[1] [*8]; endsequence
	property p_ready; s_setup |=> pready; endproperty
	property p_idle; !penable |-> !pready; endproperty
	property p_err; s_setup ##0 (paddr == 8'h30) |=> pslverr; endproperty
	property p_ok;
		s_setup ##0 (paddr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14,
			8'h18, 8'h20, 8'h24, 8'h28, 8'h2c}) |=> !pslverr;
	endproperty
	property p_off0; s_off0 |-> !power_out[0]; endproperty
	property p_off1; s_off1 |-> !power_out[1]; endproperty
	// Trip never exceeds the top value, so this holds for any setting
	property p_trip; (current_in[0] >= TRIP_MAX) [*8] |-> !power_out[0];
	endproperty
	property p_rst; $rose(presetn) |-> power_out == '0 && !irq; endproperty
	property p_rise; $rose(power_out[0]) |-> $past(switch_in[0], 2);
	endproperty
	a_ready: assert property (p_ready) else $error("no pready");
	a_idle: assert property (p_idle) else $error("stray pready");
	a_err: assert property (p_err) else $error("no slave error");
	a_ok: assert property (p_ok) else $error("false slave error");
	a_off0: assert property (p_off0) else $error("ch0 on, sw off");
	a_off1: assert property (p_off1) else $error("ch1 on, sw off");
	a_trip: assert property (p_trip) else $error("ch0 not tripped");
	a_rst: assert property (p_rst) else $error("outputs after reset");
	a_rise: assert property (p_rise) else $error("ch0 on, no sw");
endmodule : iaoc_checker
bind iaoc_top iaoc_checker #(.NUM_CH(NUM_CH)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr),
	.switch_in(switch_in), .current_in(current_in),
	.power_out(power_out), .irq(irq)
);

// ===== sim/iaoc_partner.sv
// Model of the cab switches, current sense and vehicle status lines.
// Commands from the bench reach the pins one clock later.
`timescale 1ns/1ps
module iaoc_partner (
	input wire logic pclk,
	input wire logic [1:0] sw_cmd,
	input wire logic [1:0][7:0] cur_cmd,
	input wire iaoc_pkg::iaoc_veh_t veh_cmd,
	input wire logic [7:0] gear_ofs,
	output logic [1:0] switch_in = 2'h0,
	output logic [1:0][7:0] current_in = 16'h0,
	output iaoc_pkg::iaoc_veh_t veh_in = '0
);
	import iaoc_pkg::*;
	// Own switch and sense line per channel
	always @(posedge pclk) begin
		switch_in <= sw_cmd;
		current_in <= cur_cmd;
	end
	// Gear is neutral plus forward count; reverse counts go below it
	always @(posedge pclk) begin
		veh_in <= {veh_cmd[19:8], GEAR_NEUTRAL + gear_ofs};
	end
endmodule : iaoc_partner

// ===== sim/tb_interlocked_aux_output_ctrl.sv
// Self-checking bench for the two-channel interlocked output block.
// Assumes the partner model and the design share the one bus clock.
`timescale 1ns/1ps
module tb_interlocked_aux_output_ctrl;
	import iaoc_pkg::*;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, irq, ia;
	logic [1:0] sw = 2'h0;
	logic [1:0] switch_in, power_out;
	logic [1:0][7:0] cur = 16'h0;
	logic [1:0][7:0] current_in;
	iaoc_veh_t vc = '0;
	iaoc_veh_t veh_in, v, ve;
	logic [7:0] gn = 8'h00;
	logic [7:0] gv, gc;
	logic [6:0] thr;
	logic [4:0] s;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	always #10 pclk = ~pclk;
	// Cut a hung run short
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end
	iaoc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.switch_in(switch_in), .current_in(current_in), .veh_in(veh_in),
		.power_out(power_out), .irq(irq));
	iaoc_partner u_cab (.pclk(pclk), .sw_cmd(sw), .cur_cmd(cur),
		.veh_cmd(vc), .gear_ofs(gn), .switch_in(switch_in),
		.current_in(current_in), .veh_in(veh_in));
	// One APB transfer; read data taken at the pready edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Only the cycle ceiling ends a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// New cab state, then wait out the pin filters
	task drive(input logic [1:0] w, input iaoc_veh_t x, input logic [15:0] c);
		@(posedge pclk);
		sw <= w;
		vc <= x;
		cur <= c;
		repeat (10) @(posedge pclk);
	endtask : drive
	// Expected output for a selector setting, switch on
	function logic f_on(input logic [4:0] q, input iaoc_veh_t x,
		input logic [6:0] t, input logic [7:0] g);
		logic [16:0] c;
		c = {x.gear != 8'h7d, x.gear == 8'h7d, x.gear < g, x.gear > g,
			x.moving, !x.moving, x.speed < t, x.speed > t, !x.engine_run,
			x.engine_run, !x.power_takeoff, x.power_takeoff, !x.door_open,
			x.door_open, !x.park_brake, x.park_brake, 1'h1};
		return (q <= 5'h10) ? c[q] : 1'h0;
	endfunction : f_on
	task stop_test();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	initial begin
		void'($urandom(32'hd38d));
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		// Defaults of both channels
		for (int n = 0; n < 2; n++) begin
			apb(1'h0, 8'(16 * n), 32'h0);
			chk(rd, 32'h00001e0a);
			apb(1'h0, 8'(16 * n + 4), 32'h0);
			chk(rd, 32'h0);
			apb(1'h0, 8'(16 * n + 8), 32'h0);
			chk(rd, 32'hc8);
		end
		// Out-of-range settings are refused or clamped
		apb(1'h1, 8'h00, 32'h00006511);
		apb(1'h0, 8'h00, 32'h0);
		chk(rd, 32'h0000640a);
		apb(1'h1, 8'h04, 32'hfb);
		apb(1'h0, 8'h04, 32'h0);
		chk(rd, 32'hfa);
		apb(1'h1, 8'h08, 32'h05);
		apb(1'h0, 8'h08, 32'h0);
		chk(rd, 32'h0a);
		apb(1'h1, 8'h08, 32'hc8);
		apb(1'h0, 8'h30, 32'h0);
		chk(32'(er), 32'h1);
		// Every setting with random status; channel 1 stays at default
		for (int i = 0; i < 51; i++) begin
			s = 5'(i % 17);
			thr = 7'($urandom_range(100));
			gv = 8'($urandom_range(10) - 5);
			gc = 8'h7d + 8'($urandom_range(6)) - 8'h03;
			v = iaoc_veh_t'(20'($urandom));
			if (i < 17)
				v.speed = thr;
			ve = v;
			ve.gear = 8'h7d + gv;
			apb(1'h1, 8'h00, {17'h0, thr, 3'h0, s});
			apb(1'h1, 8'h04, {24'h0, gc});
			gn <= gv;
			drive(2'h3, v, {8'($urandom_range(199)), 8'($urandom_range(199))});
			chk(32'(power_out), 32'({f_on(5'h0a, ve, 7'h1e, 8'h00),
				f_on(s, ve, thr, gc)}));
		end
		// Latch-off on the park brake setting
		apb(1'h1, 8'h28, 32'hf);
		apb(1'h1, 8'h00, 32'h00011e01);
		v = '0;
		v.park_brake = 1'h1;
		drive(2'h1, v, 16'h0);
		chk(32'(power_out), 32'h1);
		v.park_brake = 1'h0;
		drive(2'h1, v, 16'h0);
		chk(32'(power_out), 32'h0);
		apb(1'h0, 8'h28, 32'h0);
		chk(rd & 32'h5, 32'h1);
		v.park_brake = 1'h1;
		drive(2'h1, v, 16'h0);
		chk(32'(power_out), 32'h0);
		drive(2'h0, v, 16'h0);
		drive(2'h1, v, 16'h0);
		chk(32'(power_out), 32'h1);
		// Trip exactly at the programmed value, held until recycle
		drive(2'h1, v, 16'h00c8);
		chk(32'(power_out), 32'h0);
		drive(2'h1, v, 16'h0);
		chk(32'(power_out), 32'h0);
		apb(1'h0, 8'h28, 32'h0);
		chk(rd & 32'h4, 32'h4);
		apb(1'h0, 8'h24, 32'h0);
		chk(rd, 32'h14);
		apb(1'h0, 8'h20, 32'h0);
		chk(rd, 32'({v[19:8], 8'(GEAR_NEUTRAL + gn)}));
		drive(2'h0, v, 16'h0);
		drive(2'h1, v, 16'h0);
		chk(32'(power_out), 32'h1);
		// Unmasking raises the line; clearing the status drops it
		apb(1'h1, 8'h2c, 32'h0);
		repeat (2) @(posedge pclk);
		ia = irq;
		apb(1'h1, 8'h2c, 32'hf);
		repeat (2) @(posedge pclk);
		chk(32'(ia ^ irq), 32'h1);
		apb(1'h1, 8'h28, 32'hf);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0);
		apb(1'h1, 8'h2c, 32'h0);
		apb(1'h0, 8'h28, 32'h0);
		chk(rd, 32'h0);
		stop_test();
	end
endmodule : tb_interlocked_aux_output_ctrl
